/* pkg/iir_smoother_pkg.sv */
// constants and types for the analog input smoothing filter
// Operation
// R1: step filter once per new conversion result
// R2: new value from previous value and sample
// R3: larger constant gives newest sample less weight
// R4: smoothing time follows constant and cycle time
// R5: cycle time 0.03, 0.09 or 0.13 s
// R6: constant 0..7, zero passes raw sample through
// R7: step reaches 63 percent after tabulated time
// R8: weight by right shift, keep fraction bits
package iir_smoother_pkg;
    localparam int DATA_W = 16;
    localparam int FRAC_W = 8;
    localparam int ACC_W = DATA_W + FRAC_W;
    localparam int CONST_W = 3;
    localparam int NUM_CHAN = 2;
    localparam int CHAN_W = 1;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 2;
    // core clock rate
    localparam int CLK_MHZ = 100;
    // total two-channel conversion cycle times, in microseconds
    localparam int CONV_FAST_US = 30000;
    localparam int CONV_MID_US = 90000;
    localparam int CONV_SLOW_US = 130000;
    localparam int CONV_FAST_CYC = CONV_FAST_US * CLK_MHZ;
    localparam int CONV_MID_CYC = CONV_MID_US * CLK_MHZ;
    localparam int CONV_SLOW_CYC = CONV_SLOW_US * CLK_MHZ;
    localparam int TIMER_W = 32;
    // values after reset and special codes
    localparam logic [ACC_W-1:0] ACC_RESET = 24'h0000_00;
    localparam logic [CONST_W-1:0] CONST_BYPASS = 3'h0;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0000_0000;
    // conversion cycle choice, from the number of slow-mode channels
    typedef enum logic [1:0] {
        CYC_FAST = 2'b00,
        CYC_MID = 2'b01,
        CYC_SLOW = 2'b10
    } cycle_sel_t;
    // filter sequencer
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CALC = 2'b01,
        S_SEND = 2'b10
    } filt_state_t;
endpackage : iir_smoother_pkg

/* design/sample_fifo.sv */
// small first-in first-out buffer for conversion results
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;

    // handshake decode
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire wr_last = (wr_ptr_reg == PTR_W'(DEPTH - 1));
    wire rd_last = (rd_ptr_reg == PTR_W'(DEPTH - 1));
    assign in_ready = (count_reg != CNT_W'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_last ? '0 : wr_ptr_reg + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_last ? '0 : rd_ptr_reg + PTR_W'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_W'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_W'(1);
            end
        end
    end
endmodule : sample_fifo

/* design/analog_input_iir_smoother.sv */
// two-channel first-order recursive smoother for converter results
`timescale 1ns/1ps
module analog_input_iir_smoother
    import iir_smoother_pkg::*;
#(
    parameter int FAST_CYC = iir_smoother_pkg::CONV_FAST_CYC,
    parameter int MID_CYC = iir_smoother_pkg::CONV_MID_CYC,
    parameter int SLOW_CYC = iir_smoother_pkg::CONV_SLOW_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic MODE_SLOW_0,
    input wire logic MODE_SLOW_1,
    input wire logic [iir_smoother_pkg::CONST_W-1:0] FILT_CONST_0,
    input wire logic [iir_smoother_pkg::CONST_W-1:0] FILT_CONST_1,
    output logic CONV_START,
    output logic [1:0] CYCLE_SEL,
    input wire logic CONV_VALID,
    output logic CONV_READY,
    input wire logic [iir_smoother_pkg::CHAN_W-1:0] CONV_CHAN,
    input wire logic [iir_smoother_pkg::DATA_W-1:0] CONV_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [iir_smoother_pkg::CHAN_W-1:0] OUT_CHAN,
    output logic [iir_smoother_pkg::DATA_W-1:0] OUT_DATA
);
    import iir_smoother_pkg::*;

    localparam int CFG_W = 2 + 2 * CONST_W;
    localparam int FIFO_W = CHAN_W + DATA_W;

    // configuration pins pass two flip-flops
    logic [CFG_W-1:0] cfg_meta_reg;
    logic [CFG_W-1:0] cfg_sync_reg;
    wire [CFG_W-1:0] cfg_pins = {MODE_SLOW_1, MODE_SLOW_0, FILT_CONST_1, FILT_CONST_0};

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cfg_meta_reg <= '0;
            cfg_sync_reg <= '0;
        end else begin
            cfg_meta_reg <= cfg_pins;
            cfg_sync_reg <= cfg_meta_reg;
        end
    end

    // synchronised configuration fields
    wire [CONST_W-1:0] k_ch [NUM_CHAN];
    assign k_ch[0] = cfg_sync_reg[CONST_W-1:0];
    assign k_ch[1] = cfg_sync_reg[2*CONST_W-1:CONST_W];
    wire slow_0 = cfg_sync_reg[2*CONST_W];
    wire slow_1 = cfg_sync_reg[2*CONST_W+1];

    // cycle time choice from the two input modes
    cycle_sel_t cyc_sel;
    assign cyc_sel = (slow_0 && slow_1) ? CYC_SLOW
                   : (slow_0 || slow_1) ? CYC_MID : CYC_FAST; // see R5
    assign CYCLE_SEL = cyc_sel;
    wire [TIMER_W-1:0] period = (cyc_sel == CYC_SLOW) ? TIMER_W'(SLOW_CYC)
                              : (cyc_sel == CYC_MID) ? TIMER_W'(MID_CYC)
                              : TIMER_W'(FAST_CYC); // see R5

    // conversion cycle timer, one start pulse per two-channel cycle
    logic [TIMER_W-1:0] timer_reg;
    logic start_reg;
    wire timer_done = (timer_reg == TIMER_RESET);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            timer_reg <= TIMER_RESET;
            start_reg <= 1'b0;
        end else begin
            start_reg <= timer_done; // see R4
            timer_reg <= timer_done ? period - TIMER_W'(1) : timer_reg - TIMER_W'(1);
        end
    end
    assign CONV_START = start_reg;

    // results queue ahead of the filter
    logic fifo_valid;
    logic fifo_ready;
    logic [FIFO_W-1:0] fifo_data;

    sample_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst(RST),
        .in_valid(CONV_VALID),
        .in_ready(CONV_READY),
        .in_data({CONV_CHAN, CONV_DATA}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // sequencer state and latched sample
    filt_state_t state_reg;
    filt_state_t state_next;
    logic [CHAN_W-1:0] chan_reg;
    logic [DATA_W-1:0] samp_reg;
    logic [DATA_W-1:0] out_data_reg;

    wire fifo_pop = fifo_valid && fifo_ready;
    wire upd_en = (state_reg == S_CALC); // see R1
    assign fifo_ready = (state_reg == S_IDLE);
    assign OUT_VALID = (state_reg == S_SEND);
    assign OUT_CHAN = chan_reg;
    assign OUT_DATA = out_data_reg;

    // next-state decode
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (fifo_valid) begin
                    state_next = S_CALC;
                end
            end
            S_CALC: begin
                state_next = S_SEND;
            end
            S_SEND: begin
                if (OUT_READY) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // per-channel accumulators and update arithmetic
    logic [ACC_W-1:0] acc_reg [NUM_CHAN];
    logic [ACC_W-1:0] acc_next [NUM_CHAN];
    wire [ACC_W-1:0] samp_ext = {samp_reg, {FRAC_W{1'b0}}}; // see R8

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        wire signed [ACC_W:0] diff = $signed({1'b0, samp_ext}) - $signed({1'b0, acc_reg[c]});
        wire signed [ACC_W:0] step = diff >>> k_ch[c]; // see R3
        wire signed [ACC_W:0] sum = $signed({1'b0, acc_reg[c]}) + step; // see R2
        wire bypass = (k_ch[c] == CONST_BYPASS);
        assign acc_next[c] = bypass ? samp_ext : sum[ACC_W-1:0]; // see R6

        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                acc_reg[c] <= ACC_RESET;
            end else if (upd_en && (chan_reg == CHAN_W'(c))) begin
                acc_reg[c] <= acc_next[c]; // see R1
            end
        end
    end

    // sequencer registers and output data
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg <= S_IDLE;
            chan_reg <= '0;
            samp_reg <= '0;
            out_data_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (fifo_pop) begin
                chan_reg <= fifo_data[FIFO_W-1:DATA_W];
                samp_reg <= fifo_data[DATA_W-1:0];
            end
            if (upd_en) begin
                out_data_reg <= acc_next[chan_reg][ACC_W-1:FRAC_W]; // see R6
            end
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence seq_take;
        fifo_pop;
    endsequence

    sequence seq_step_and_offer;
        upd_en ##1 OUT_VALID;
    endsequence

    AST_ONE_STEP_PER_RESULT: assert property (seq_take |=> seq_step_and_offer) // see R1
        else $error("result taken without one filter step and offer");

    AST_NO_STEP_WITHOUT_RESULT: assert property (
        (acc_reg[0] != $past(acc_reg[0])) |-> $past(upd_en && chan_reg == '0)) // see R1
        else $error("channel 0 state moved without a new result");

    AST_BETWEEN_OLD_AND_NEW: assert property (
        (upd_en && chan_reg == '0) |=>
        ((acc_reg[0] >= $past(acc_reg[0]) && acc_reg[0] <= $past(samp_ext)) ||
         (acc_reg[0] <= $past(acc_reg[0]) && acc_reg[0] >= $past(samp_ext)))) // see R2
        else $error("filtered value left the old-to-sample interval");

    AST_NO_STALL: assert property (
        (upd_en && chan_reg == '0 && k_ch[0] != CONST_BYPASS && samp_ext > acc_reg[0] &&
         (samp_ext - acc_reg[0]) >= ACC_W'(1 << FRAC_W))
        |=> acc_reg[0] != $past(acc_reg[0])) // see R8
        else $error("filter stalled a full reading step below the sample");

    AST_DOWN_STEP: assert property (
        (upd_en && chan_reg == '0 && samp_ext < acc_reg[0])
        |=> acc_reg[0] < $past(acc_reg[0])) // see R8
        else $error("filter stalled above a smaller sample");

    AST_BYPASS_RAW: assert property (
        (upd_en && k_ch[chan_reg] == CONST_BYPASS) |=> OUT_DATA == $past(samp_reg)) // see R6
        else $error("constant zero did not pass the raw sample");

    AST_HALF_WEIGHT: assert property (
        (upd_en && chan_reg == '0 && k_ch[0] == 3'h1 && acc_reg[0] == ACC_RESET)
        |=> acc_reg[0] == ($past(samp_ext) >> 1)) // see R7
        else $error("constant one did not move halfway");

    AST_SMALLER_STEP: assert property ( // see R3
        (upd_en && chan_reg == '0 && k_ch[0] > 3'h1 && samp_ext > acc_reg[0])
        |=> (acc_reg[0] - $past(acc_reg[0])) <= (($past(samp_ext) - $past(acc_reg[0])) >> 1))
        else $error("larger constant gave the sample too much weight");

    AST_CYCLE_PERIOD: assert property (
        CONV_START |-> (timer_reg == period - TIMER_W'(1)) || $changed(period)) // see R5
        else $error("conversion cycle timer reloaded with the wrong period");

    AST_OFFER_HOLDS: assert property ( // see R1
        (OUT_VALID && !OUT_READY) |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_CHAN))
        else $error("offered reading changed before it was taken");

    AST_QUEUE_FULL: assert property (
        (!CONV_READY && fifo_ready) |=> CONV_READY) // see R1
        else $error("queue stayed full after the filter took a result");

    // converter pacing and cycle choice checks
    sequence seq_start;
        CONV_START;
    endsequence

    sequence seq_gap_after_start;
        !CONV_START ##1 !CONV_START;
    endsequence

    AST_START_SINGLE: assert property (seq_start |=> seq_gap_after_start) // see R4
        else $error("conversion start pulse lasted more than one cycle");

    AST_START_FROM_TIMER: assert property (timer_done |=> CONV_START) // see R4
        else $error("timer expired without a conversion start");

    AST_TIMER_COUNTS: assert property (
        !timer_done |=> timer_reg == $past(timer_reg) - TIMER_W'(1)) // see R4
        else $error("conversion timer skipped a count");

    AST_SELECT_SLOW: assert property (
        (slow_0 && slow_1) |-> CYCLE_SEL == CYC_SLOW) // see R5
        else $error("two slow inputs did not give the longest cycle");

    AST_SELECT_MID: assert property (
        (slow_0 != slow_1) |-> CYCLE_SEL == CYC_MID) // see R5
        else $error("one slow input did not give the middle cycle");

    AST_SELECT_FAST: assert property (
        (!slow_0 && !slow_1) |-> CYCLE_SEL == CYC_FAST) // see R5
        else $error("no slow input did not give the shortest cycle");

    // reading, sample and channel state checks
    sequence seq_offer_taken;
        OUT_VALID && OUT_READY;
    endsequence

    sequence seq_back_to_idle;
        !OUT_VALID && fifo_ready;
    endsequence

    AST_TAKE_RELEASES: assert property (seq_offer_taken |=> seq_back_to_idle) // see R1
        else $error("reading still offered after it was taken");

    AST_OFFER_AFTER_STEP: assert property ($rose(OUT_VALID) |-> $past(upd_en)) // see R1
        else $error("reading offered without a filter step");

    AST_OFFER_MATCHES_STATE: assert property (
        OUT_VALID |-> OUT_DATA == acc_reg[chan_reg][ACC_W-1:FRAC_W]) // see R2
        else $error("offered reading differs from the channel state");

    AST_SAMPLE_ON_TAKE: assert property (
        (samp_reg != $past(samp_reg)) |-> $past(fifo_pop)) // see R1
        else $error("latched sample changed without a taken result");

    AST_CHAN_ON_TAKE: assert property (
        (chan_reg != $past(chan_reg)) |-> $past(fifo_pop)) // see R1
        else $error("latched channel changed without a taken result");

    AST_NO_STEP_CH1: assert property (
        (acc_reg[1] != $past(acc_reg[1])) |-> $past(upd_en && chan_reg == 1'b1)) // see R1
        else $error("channel 1 state moved without a new result");

    AST_BETWEEN_CH1: assert property (
        (upd_en && chan_reg == 1'b1) |=>
        ((acc_reg[1] >= $past(acc_reg[1]) && acc_reg[1] <= $past(samp_ext)) ||
         (acc_reg[1] <= $past(acc_reg[1]) && acc_reg[1] >= $past(samp_ext)))) // see R2
        else $error("channel 1 value left the old-to-sample interval");
endmodule : analog_input_iir_smoother

/* sim/adc_model.sv */
// behavioural converter that answers each enabled conversion start arriving while idle with two results
`timescale 1ns/1ps
module adc_model
    import iir_smoother_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [iir_smoother_pkg::DATA_W-1:0] sample_0,
    input wire logic [iir_smoother_pkg::DATA_W-1:0] sample_1,
    input wire logic conv_start,
    input wire logic conv_ready,
    output logic conv_valid,
    output logic [iir_smoother_pkg::CHAN_W-1:0] conv_chan,
    output logic [iir_smoother_pkg::DATA_W-1:0] conv_data
);
    logic [1:0] left_reg;

    initial begin
        left_reg = 2'h0;
        conv_valid = 1'b0;
        conv_chan = 1'b0;
        conv_data = 16'h0000;
    end

    // offer channel 0 then channel 1, holding each offer until it is taken
    always @(posedge clk) begin
        if (rst) begin
            left_reg <= 2'h0;
            conv_valid <= 1'b0;
        end else if (conv_valid && !conv_ready) begin
            conv_valid <= 1'b1; // refused: keep offering the same result
        end else if (left_reg != 2'h0) begin
            conv_valid <= 1'b1;
            conv_chan <= (left_reg == 2'h2) ? 1'b0 : 1'b1;
            conv_data <= (left_reg == 2'h2) ? sample_0 : sample_1;
            left_reg <= left_reg - 2'h1;
        end else begin
            conv_valid <= 1'b0;
            conv_data <= ~conv_data; // released bus inverts every bit each idle cycle, so the last result reappears every second cycle
            if (conv_start && enable) begin
                left_reg <= 2'h2;
            end
        end
    end
endmodule : adc_model

/* sim/tb_top.sv */
// self-checking bench for the analog input smoothing filter
`timescale 1ns/1ps
module tb_top;
    import iir_smoother_pkg::*;
    localparam int FAST = 30;
    localparam int MID = 90;
    localparam int SLOW = 130;
    logic clk, rst, mode_0, mode_1, conv_start, conv_valid, conv_ready, out_valid, out_ready;
    logic en, hold, step, saw_full;
    logic [CONST_W-1:0] k_0, k_1;
    logic [1:0] cyc_sel;
    logic [CHAN_W-1:0] conv_chan, out_chan;
    logic [DATA_W-1:0] conv_data, out_data, s_0, s_1;
    int n_mismatch = 0;
    int n_tests = 0;
    int acc [2] = '{0, 0};
    int q_chan [$];
    int q_data [$];
    int ch, kk, d, per, seed;

    analog_input_iir_smoother #(.FAST_CYC(FAST), .MID_CYC(MID), .SLOW_CYC(SLOW)) i_dut (
        .CORE_CLK(clk), .RST(rst), .MODE_SLOW_0(mode_0), .MODE_SLOW_1(mode_1),
        .FILT_CONST_0(k_0), .FILT_CONST_1(k_1), .CONV_START(conv_start), .CYCLE_SEL(cyc_sel),
        .CONV_VALID(conv_valid), .CONV_READY(conv_ready), .CONV_CHAN(conv_chan),
        .CONV_DATA(conv_data), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_CHAN(out_chan), .OUT_DATA(out_data));

    adc_model i_adc (.clk(clk), .rst(rst), .enable(en), .sample_0(s_0), .sample_1(s_1),
        .conv_start(conv_start), .conv_ready(conv_ready), .conv_valid(conv_valid),
        .conv_chan(conv_chan), .conv_data(conv_data));

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (exp !== got) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // random consumer stalls and samples, steady full scale for a step
    always @(posedge clk) begin
        out_ready <= hold ? 1'b0 : 1'($urandom % 4 != 0);
        s_0 <= step ? 16'hffff : 16'($urandom);
        s_1 <= step ? 16'hffff : 16'($urandom);
        if (conv_ready === 1'b0) saw_full <= 1'b1;
    end

    // reference model: queue taken results, filter them at each taken reading
    always @(posedge clk) begin
        if (!rst && conv_valid && conv_ready === 1'b1) begin
            q_chan.push_back(conv_chan);
            q_data.push_back(conv_data);
        end
        if (!rst && out_valid === 1'b1 && out_ready) begin
            if (q_chan.size() == 0) begin
                check("unexpected reading", 0, 1);
            end else begin
                ch = q_chan.pop_front();
                d = q_data.pop_front();
                kk = ch ? k_1 : k_0;
                if (kk == 0) acc[ch] = d <<< 8;
                else acc[ch] = acc[ch] + (((d <<< 8) - acc[ch]) >>> kk);
                check("reading channel", ch, out_chan);
                check("reading value", acc[ch] >>> 8, out_data);
            end
        end
    end

    task automatic drain();
        @(posedge clk);
        en <= 1'b0;
        hold <= 1'b0;
        repeat (300) @(posedge clk);
        check("results left over", 0, q_chan.size());
    endtask : drain

    task automatic run_case(logic [2:0] c0, logic [2:0] c1, int slow, int nconv, bit stall,
                            bit stp);
        drain();
        k_0 <= c0;
        k_1 <= c1;
        mode_0 <= (slow == 2) || (slow == 1 && !c0[0]); // one slow input alternates
        mode_1 <= (slow == 2) || (slow == 1 && c0[0]);
        step <= stp;
        repeat (5) @(negedge clk);
        check("cycle select", slow, cyc_sel);
        for (per = 0; per < 400 && conv_start !== 1'b1; per++) @(negedge clk);
        per = 0;
        do begin
            @(negedge clk);
            per++;
        end while (per < 400 && conv_start !== 1'b1);
        check("start period", slow == 0 ? FAST : slow == 1 ? MID : SLOW, per);
        @(posedge clk);
        en <= 1'b1;
        hold <= stall;
        saw_full <= 1'b0;
        repeat (nconv * per) @(posedge clk);
        if (stall) check("refused while full", 1, saw_full);
        $display("test done k0 %0d k1 %0d cycle %0d", c0, c1, slow);
    endtask : run_case

    initial begin
        rst = 1'b1;
        en = 1'b0;
        hold = 1'b0;
        step = 1'b0;
        saw_full = 1'b0;
        out_ready = 1'b0;
        mode_0 = 1'b0;
        mode_1 = 1'b0;
        k_0 = 3'h0;
        k_1 = 3'h0;
        s_0 = 16'h0000;
        s_1 = 16'h0000;
        seed = $urandom(32'h0000_72fd);
        repeat (6) @(posedge clk);
        check("ready in reset", 1, conv_ready);
        check("reading in reset", 0, out_valid);
        rst <= 1'b0;
        run_case(3'h1, 3'h7, 0, 8, 0, 1);
        for (int k = 0; k < 8; k++) run_case(3'(k), 3'(7 - k), k % 3, 5, 0, 0);
        run_case(3'h2, 3'h5, 0, 5, 1, 0);
        drain();
        report_and_stop();
    end

    // cut a hang short well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
